// *** design/fdc_cmd_engine.sv ***
// Disk command engine: scan low/high, seek, recalibrate, sense interrupt, specify.
// Assumes the host end on the link and a data separator feeding disk bytes on clk.
// Functional notes
// [RULE_01] Low scan: disk byte must not exceed host
// [RULE_02] High scan: disk byte must not undercut host
// [RULE_03] Scan: nine command bytes, seven result bytes
// [RULE_04] Low scan flags: hit, none, miss; ready check
// [RULE_05] High scan flags: none, hit, miss; ready check
// [RULE_06] ID field errors map to status flags
// [RULE_07] Low scan data errors: fault, overrun, incomplete
// [RULE_08] High scan data errors: marks, crc, overrun
// [RULE_09] Seek: opcode, drive byte, target cylinder
// [RULE_10] Seek to present cylinder ends at once
// [RULE_11] Step outward and increment below target
// [RULE_12] Step inward and decrement above target
// [RULE_13] Seek status: seek end, or not ready
// [RULE_14] No automatic status after seek or recalibrate
// [RULE_15] Engine stays free while drives step
// [RULE_16] Scans refused while any drive steps
// [RULE_17] Recalibrate steps home, gives up after 255
// [RULE_18] Recalibrate status: end, not ready, equipment
// [RULE_19] Sense clears interrupt, returns status, cylinder
// [RULE_20] Interrupt code encoding in status zero
// [RULE_21] Sense without pending interrupt returns invalid
// [RULE_22] Returned cylinder belongs to reported drive
// [RULE_23] Step pacing from last programmed step rate
// [RULE_24] Interrupt request raised on seek completion
`timescale 1ns/100ps
`default_nettype none
module fdc_cmd_engine
  import fdc_pkg::*;
#(
  parameter int STEP_UNIT = STEP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  fdc_link_if.dev link,
  output logic [NUM_DRIVES-1:0] step,
  output logic [NUM_DRIVES-1:0] step_dir,
  input wire logic [NUM_DRIVES-1:0] home_track_input,
  input wire logic [NUM_DRIVES-1:0] drive_ready,
  output logic scan_active,
  input wire logic disk_valid,
  input wire logic [7:0] disk_byte,
  input wire logic disk_done,
  input wire logic [FAULT_W-1:0] disk_fault,
  input wire logic [7:0] disk_cyl
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [NUM_DRIVES-1:0] home_s1_reg, home_s2_reg, rdy_s1_reg, rdy_s2_reg;
  phase_t phase_reg;
  logic [7:0] cmd_buf [0:8];
  logic [3:0] cnt_reg, len_reg;
  logic [7:0] res_buf [0:6];
  logic [2:0] res_left_reg;
  logic [3:0] srt_reg;
  logic [31:0] div_reg;
  logic tick_reg;
  logic [7:0] pcn_reg [0:NUM_DRIVES-1];
  logic [7:0] ncn_reg [0:NUM_DRIVES-1];
  logic [4:0] wait_reg [0:NUM_DRIVES-1];
  logic [7:0] steps_reg [0:NUM_DRIVES-1];
  logic [7:0] pend_st0_reg [0:NUM_DRIVES-1];
  logic [NUM_DRIVES-1:0] seek_reg, recal_reg, pend_reg, step_reg, dir_reg;
  logic [7:0] host_byte_reg;
  logic host_full_reg, miss_reg, neq_reg, over_reg;
  logic busy_reg, int_reg, seeking_reg;
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [7:0] op;
  logic [3:0] need;
  logic take, last, refuse;
  logic seek_go, recal_go, sense_go, scan_go;
  logic [1:0] go_drv, sense_drv;
  logic sense_hit;
  logic [7:0] st0, st1, st2;

  // Pins cross into clk through two flops
  always_ff @(posedge clk)
  begin
    home_s1_reg <= home_track_input;
    home_s2_reg <= home_s1_reg;
    rdy_s1_reg <= drive_ready;
    rdy_s2_reg <= rdy_s1_reg;
  end

  always_comb
  begin
    op = (cnt_reg == 4'h0) ? link.wdata : cmd_buf[0];
    need = (cnt_reg == 4'h0) ? cmd_len(link.wdata) : len_reg;
    take = link.wr && phase_reg == PH_CMD;
    refuse = take && cnt_reg == 4'h0 && (need == 4'h0 || (is_scan(op) && seeking_reg)); // [RULE_16]
    last = take && !refuse && need == cnt_reg + 4'h1;
    seek_go = last && op == OP_SEEK; // [RULE_09]
    recal_go = last && op == OP_RECAL;
    sense_go = last && op == OP_SENSE;
    scan_go = last && is_scan(op); // [RULE_03]
    go_drv = recal_go ? link.wdata[1:0] : cmd_buf[1][1:0];
    sense_hit = 1'b0;
    sense_drv = 2'h0;
    for (int i = NUM_DRIVES - 1; i >= 0; i--)
      if (pend_reg[i])
      begin
        sense_hit = 1'b1;
        sense_drv = 2'(i);
      end
  end

  // Scan result bytes built from comparison flags and separator faults
  always_comb
  begin
    st0 = {6'h00, cmd_buf[1][1:0]};
    st1 = 8'h00;
    st2 = 8'h00;
    st0[ST0_HD] = cmd_buf[1][2];
    if (!rdy_s2_reg[cmd_buf[1][1:0]])
    begin
      st0[ST0_IC_LO] = 1'b1; // [RULE_04] [RULE_05]
      st0[ST0_NR] = 1'b1;
    end
    else
    begin
      st2[ST2_SN] = miss_reg; // [RULE_01] [RULE_02] [RULE_04] [RULE_05]
      st2[ST2_SH] = !miss_reg && !neq_reg;
      if (disk_fault[F_ID_MISSING])
        {st0[ST0_IC_LO], st1[ST1_MA]} = 2'b11; // [RULE_06]
      if (disk_fault[F_CYL])
      begin
        {st0[ST0_IC_LO], st1[ST1_ND]} = 2'b11; // [RULE_06]
        st2[ST2_BC] = disk_cyl == BAD_CYL;
        st2[ST2_NC] = disk_cyl != BAD_CYL;
      end
      if (disk_fault[F_HSN])
        {st0[ST0_IC_LO], st1[ST1_ND]} = 2'b11; // [RULE_06]
      if (disk_fault[F_ID_CRC])
        {st0[ST0_IC_LO], st1[ST1_DE]} = 2'b11; // [RULE_06]
      if (over_reg)
        {st0[ST0_IC_LO], st1[ST1_OR]} = 2'b11; // [RULE_07] [RULE_08]
      if (cmd_buf[0][4:0] == OP_SCAN_LE)
      begin
        if (disk_fault[F_FAULT])
          {st0[ST0_IC_LO], st1[ST1_DE]} = 2'b11; // [RULE_07]
        if (disk_fault[F_INCOMPLETE])
          {st0[ST0_IC_LO], st1[ST1_EN]} = 2'b11; // [RULE_07]
      end
      else
      begin
        if (disk_fault[F_DAM_MISSING])
          {st0[ST0_IC_LO], st1[ST1_MA], st2[ST2_MD]} = 3'b111; // [RULE_08]
        if (disk_fault[F_DELETED])
          st2[ST2_CM] = 1'b1; // [RULE_08]
        if (disk_fault[F_DATA_CRC])
          {st0[ST0_IC_LO], st1[ST1_DE], st2[ST2_DD]} = 3'b111; // [RULE_08]
      end
    end
  end

  // ----------------------------------------
  // Command, execution and result phases
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_reg <= PH_CMD;
      cnt_reg <= 4'h0;
      len_reg <= 4'h0;
      res_left_reg <= 3'h0;
      srt_reg <= SRT_RESET;
      for (int k = 0; k < 9; k++)
        cmd_buf[k] <= 8'h00;
      for (int k = 0; k < 7; k++)
        res_buf[k] <= 8'h00;
    end
    else if (take)
    begin
      cmd_buf[cnt_reg] <= link.wdata;
      cnt_reg <= (last || refuse) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg == 4'h0)
        len_reg <= need;
      if (refuse)
      begin
        res_buf[0] <= ST0_INVALID;
        res_left_reg <= RES_INVALID;
        phase_reg <= PH_RESULT;
      end
      else if (last && op == OP_SPECIFY)
        srt_reg <= cmd_buf[1][7:4]; // [RULE_23]
      else if (sense_go)
      begin
        // Sense returns status then cylinder; nothing pending gives one invalid byte
        res_buf[0] <= sense_hit ? pend_st0_reg[sense_drv] : ST0_INVALID; // [RULE_19] [RULE_21]
        res_buf[1] <= pcn_reg[sense_drv]; // [RULE_22]
        res_left_reg <= sense_hit ? RES_SENSE : RES_INVALID;
        phase_reg <= PH_RESULT;
      end
      else if (scan_go)
        phase_reg <= rdy_s2_reg[cmd_buf[1][1:0]] ? PH_EXEC : PH_RESULT;
      if (scan_go && !rdy_s2_reg[cmd_buf[1][1:0]])
      begin
        res_buf[0] <= st0; // [RULE_04] [RULE_05]
        res_buf[1] <= 8'h00;
        res_buf[2] <= 8'h00;
        for (int k = 0; k < 4; k++)
          res_buf[3 + k] <= cmd_buf[2 + k]; // [RULE_03]
        res_left_reg <= RES_SCAN;
      end
    end
    else if (phase_reg == PH_EXEC && disk_done)
    begin
      res_buf[0] <= st0; // [RULE_03]
      res_buf[1] <= st1;
      res_buf[2] <= st2;
      for (int k = 0; k < 4; k++)
        res_buf[3 + k] <= cmd_buf[2 + k];
      res_left_reg <= RES_SCAN;
      phase_reg <= PH_RESULT;
    end
    else if (phase_reg == PH_RESULT && link.rd)
    begin
      for (int k = 0; k < 6; k++)
        res_buf[k] <= res_buf[k + 1];
      res_left_reg <= res_left_reg - 3'h1;
      if (res_left_reg == 3'h1)
        phase_reg <= PH_CMD;
    end
  end

  // Scan comparison; a disk byte with no host byte waiting is an overrun
  always_ff @(posedge clk)
  begin
    if (rst || scan_go)
    begin
      host_full_reg <= 1'b0;
      host_byte_reg <= 8'h00;
      miss_reg <= 1'b0;
      neq_reg <= 1'b0;
      over_reg <= 1'b0;
    end
    else if (phase_reg == PH_EXEC)
    begin
      if (disk_valid)
      begin
        if (!host_full_reg)
          over_reg <= 1'b1; // [RULE_07] [RULE_08]
        else
        begin
          if (cmd_buf[0][4:0] == OP_SCAN_LE ? disk_byte > host_byte_reg
                                            : disk_byte < host_byte_reg)
            miss_reg <= 1'b1; // [RULE_01] [RULE_02]
          if (disk_byte != host_byte_reg)
            neq_reg <= 1'b1;
        end
        host_full_reg <= 1'b0;
      end
      if (link.wr)
      begin
        host_byte_reg <= link.wdata;
        host_full_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Step pacing
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || div_reg == 32'(STEP_UNIT - 1))
      div_reg <= 32'h0;
    else
      div_reg <= div_reg + 32'h1;
    tick_reg <= !rst && div_reg == 32'(STEP_UNIT - 1);
  end

  // ----------------------------------------
  // Per-drive seek and recalibrate; every drive steps on its own
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seek_reg <= '0;
      recal_reg <= '0;
      pend_reg <= '0;
      step_reg <= '0;
      dir_reg <= '0;
      for (int i = 0; i < NUM_DRIVES; i++)
      begin
        pcn_reg[i] <= 8'h00;
        ncn_reg[i] <= 8'h00;
        wait_reg[i] <= 5'h00;
        steps_reg[i] <= 8'h00;
        pend_st0_reg[i] <= 8'h00;
      end
    end
    else
    begin
      step_reg <= '0;
      if (sense_go && sense_hit)
        pend_reg[sense_drv] <= 1'b0; // [RULE_19]
      for (int i = 0; i < NUM_DRIVES; i++)
      begin
        if ((seek_go || recal_go) && go_drv == 2'(i))
        begin
          steps_reg[i] <= 8'h00;
          wait_reg[i] <= 5'h00;
          if (seek_go)
            ncn_reg[i] <= link.wdata;
          if (!rdy_s2_reg[i])
          begin
            pend_st0_reg[i] <= 8'h68 | 8'(i); // [RULE_13] [RULE_18] [RULE_20]
            pend_reg[i] <= 1'b1; // [RULE_24]
          end
          else
          begin
            seek_reg[i] <= seek_go; // [RULE_15]
            recal_reg[i] <= recal_go; // [RULE_17]
          end
        end
        else if ((seek_reg[i] || recal_reg[i]) && tick_reg)
        begin
          if (wait_reg[i] != 5'h00)
            wait_reg[i] <= wait_reg[i] - 5'h01; // [RULE_23]
          else if (seek_reg[i] ? pcn_reg[i] == ncn_reg[i] : home_s2_reg[i])
          begin
            // Finished: status waits for sense, no automatic result
            seek_reg[i] <= 1'b0; // [RULE_10] [RULE_14]
            recal_reg[i] <= 1'b0;
            if (recal_reg[i])
              pcn_reg[i] <= 8'h00;
            pend_st0_reg[i] <= 8'h20 | 8'(i); // [RULE_13] [RULE_18]
            pend_reg[i] <= 1'b1; // [RULE_24]
          end
          else if (recal_reg[i] && steps_reg[i] == MAX_RECAL_STEPS)
          begin
            recal_reg[i] <= 1'b0; // [RULE_17]
            pend_st0_reg[i] <= 8'h70 | 8'(i); // [RULE_18] [RULE_20]
            pend_reg[i] <= 1'b1;
          end
          else
          begin
            step_reg[i] <= 1'b1;
            wait_reg[i] <= SRT_SPAN - {1'b0, srt_reg} - 5'h01; // [RULE_23]
            steps_reg[i] <= steps_reg[i] + 8'h01;
            dir_reg[i] <= seek_reg[i] && pcn_reg[i] < ncn_reg[i];
            if (seek_reg[i] && pcn_reg[i] < ncn_reg[i])
              pcn_reg[i] <= pcn_reg[i] + 8'h01; // [RULE_11]
            else if (seek_reg[i])
              pcn_reg[i] <= pcn_reg[i] - 8'h01; // [RULE_12]
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Registered link status
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    busy_reg <= !rst && (phase_reg != PH_CMD || cnt_reg != 4'h0);
    int_reg <= !rst && |pend_reg; // [RULE_24]
    seeking_reg <= !rst && |(seek_reg | recal_reg); // [RULE_16]
  end

  assign link.rdata = res_buf[0];
  assign link.rdata_next = res_buf[1];
  // Phase codes keep result and exec each on one flop bit
  assign link.res_avail = phase_reg[1];
  assign link.busy = busy_reg;
  assign link.int_req = int_reg;
  assign link.seek_active = seeking_reg;
  assign step = step_reg;
  assign step_dir = dir_reg;
  assign scan_active = phase_reg[0];
endmodule // fdc_cmd_engine
`default_nettype wire

// *** design/fdc_pkg.sv ***
// Shared constants for the disk command engine and its host-side controller.
// Assumes a 100 MHz clock and up to four drives.
package fdc_pkg;
  // ----------------------------------------
  // Opcodes and lengths
  // ----------------------------------------
  localparam int NUM_DRIVES = 4;
  localparam logic [7:0] OP_SEEK = 8'h0F;
  localparam logic [7:0] OP_RECAL = 8'h07;
  localparam logic [7:0] OP_SENSE = 8'h08;
  localparam logic [7:0] OP_SPECIFY = 8'h03;
  localparam logic [4:0] OP_SCAN_LE = 5'h19;
  localparam logic [4:0] OP_SCAN_HE = 5'h1D;
  localparam logic [3:0] LEN_SCAN = 4'h9;
  localparam logic [3:0] LEN_SEEK = 4'h3;
  localparam logic [3:0] LEN_RECAL = 4'h2;
  localparam logic [3:0] LEN_SENSE = 4'h1;
  localparam logic [3:0] LEN_SPECIFY = 4'h3;
  localparam logic [2:0] RES_SCAN = 3'h7;
  localparam logic [2:0] RES_SENSE = 3'h2;
  localparam logic [2:0] RES_INVALID = 3'h1;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int ST0_IC_HI = 7;
  localparam int ST0_IC_LO = 6;
  localparam int ST0_SE = 5;
  localparam int ST0_EC = 4;
  localparam int ST0_NR = 3;
  localparam int ST0_HD = 2;
  localparam int ST1_EN = 7;
  localparam int ST1_DE = 5;
  localparam int ST1_OR = 4;
  localparam int ST1_ND = 2;
  localparam int ST1_MA = 0;
  localparam int ST2_CM = 6;
  localparam int ST2_DD = 5;
  localparam int ST2_NC = 4;
  localparam int ST2_SH = 3;
  localparam int ST2_SN = 2;
  localparam int ST2_BC = 1;
  localparam int ST2_MD = 0;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] BAD_CYL = 8'hFF;
  // ----------------------------------------
  // Disk fault vector from the data separator
  // ----------------------------------------
  localparam int FAULT_W = 9;
  localparam int F_ID_MISSING = 0;
  localparam int F_CYL = 1;
  localparam int F_HSN = 2;
  localparam int F_ID_CRC = 3;
  localparam int F_DAM_MISSING = 4;
  localparam int F_DELETED = 5;
  localparam int F_DATA_CRC = 6;
  localparam int F_FAULT = 7;
  localparam int F_INCOMPLETE = 8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STEP_UNIT_US = 1000;
  localparam int STEP_UNIT_CYCLES = STEP_UNIT_US * CLK_MHZ;
  localparam logic [4:0] SRT_SPAN = 5'h10;
  localparam logic [7:0] MAX_RECAL_STEPS = 8'hFF;
  localparam logic [3:0] SRT_RESET = 4'h0;
  // ----------------------------------------
  // Host-side register map
  // ----------------------------------------
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam int HS_BUSY = 0;
  localparam int HS_RES = 1;
  localparam int HS_INT = 2;
  localparam int HS_REFUSED = 3;
  localparam int HS_SEEKING = 4;

  typedef enum logic [1:0] {PH_CMD = 2'b00, PH_EXEC = 2'b01, PH_RESULT = 2'b10} phase_t;

  function automatic logic [3:0] cmd_len(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    if (op[4:0] == OP_SCAN_LE || op[4:0] == OP_SCAN_HE)
      n = LEN_SCAN;
    else if (op == OP_SEEK)
      n = LEN_SEEK;
    else if (op == OP_RECAL)
      n = LEN_RECAL;
    else if (op == OP_SENSE)
      n = LEN_SENSE;
    else if (op == OP_SPECIFY)
      n = LEN_SPECIFY;
    return n;
  endfunction

  function automatic logic is_scan(input logic [7:0] op);
    return op[4:0] == OP_SCAN_LE || op[4:0] == OP_SCAN_HE;
  endfunction
endpackage

// *** design/fdc_link_if.sv ***
// Byte link between the host controller and the disk command engine.
// Both ends run on the same clock; the bench joins them.
`timescale 1ns/100ps
`default_nettype none
interface fdc_link_if;
  logic wr;
  logic [7:0] wdata;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] rdata_next;
  logic res_avail;
  logic busy;
  logic int_req;
  logic seek_active;
  modport dev (input wr, wdata, rd,
    output rdata, rdata_next, res_avail, busy, int_req, seek_active);
  modport host (output wr, wdata, rd,
    input rdata, rdata_next, res_avail, busy, int_req, seek_active);
endinterface
`default_nettype wire

// *** design/fdc_host_ctrl.sv ***
// Host-side controller: software register port in front of the command link.
// Assumes the engine end on the link and a single-cycle strobe master.
`timescale 1ns/100ps
`default_nettype none
module fdc_host_ctrl
  import fdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  fdc_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [3:0] rem_reg;
  logic wr_reg, rd_reg, refused_reg;
  logic [7:0] wdata_reg, rdata_reg;
  logic data_wr, opcode, block;

  always_comb
  begin
    data_wr = wr && addr == ADDR_DATA;
    opcode = data_wr && rem_reg == 4'h0 && !link.busy && !wr_reg;
    // Scans held back while drives step; they would be refused anyway
    block = opcode && is_scan(wdata) && link.seek_active; // [RULE_16]
  end

  // Count the bytes each opcode written while idle and not blocked needs, so its parameters are never taken as opcodes
  always_ff @(posedge clk)
  begin
    if (rst)
      rem_reg <= 4'h0;
    else if (opcode && !block && cmd_len(wdata) != 4'h0)
      rem_reg <= cmd_len(wdata) - 4'h1; // [RULE_03] [RULE_09]
    else if (data_wr && rem_reg != 4'h0)
      rem_reg <= rem_reg - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else
    begin
      wr_reg <= data_wr && !block;
      if (data_wr)
        wdata_reg <= wdata;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      refused_reg <= 1'b0;
    else if (block)
      refused_reg <= 1'b1;
    else if (wr && addr == ADDR_STATUS && wdata[HS_REFUSED])
      refused_reg <= 1'b0;
  end

  // A pop is seen by the engine one cycle late, so a back-to-back read takes the next byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      rd_reg <= rd && addr == ADDR_DATA && link.res_avail;
      if (rd && addr == ADDR_DATA)
        rdata_reg <= rd_reg ? link.rdata_next : link.rdata; // [RULE_14]
      else if (rd && addr == ADDR_STATUS)
        rdata_reg <= {3'h0, link.seek_active, refused_reg, link.int_req,
                      link.res_avail, link.busy || rem_reg != 4'h0};
      else
        rdata_reg <= 8'h00;
    end
  end

  assign link.wr = wr_reg;
  assign link.wdata = wdata_reg;
  assign link.rd = rd_reg;
  assign rdata = rdata_reg;
endmodule // fdc_host_ctrl
`default_nettype wire

// *** sim/disk_link_props.sv ***
// Assertions on the byte link between host controller and command engine.
// Assumes one clock and a synchronous active-high reset for both ends.
`timescale 1ns/100ps
`default_nettype none
module disk_link_props
  import fdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_next,
  input wire logic res_avail,
  input wire logic busy,
  input wire logic int_req,
  input wire logic seek_active
);
  // ----
  // Link checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sense_cmd;
    wr && wdata == OP_SENSE && !busy && !res_avail;
  endsequence
  sequence scan_cmd;
    wr && is_scan(wdata) && !busy && !res_avail;
  endsequence
  sequence refusal;
    ##[1:2] (res_avail && rdata == ST0_INVALID);
  endsequence
  sense_resp_a: assert property (sense_cmd |-> ##[1:2] res_avail)
    else $error("sense gave no result");
  invalid_code_a: assert property (sense_cmd and !int_req |-> refusal)
    else $error("empty sense not invalid");
  scan_refuse_a: assert property (scan_cmd |-> !seek_active)
    else $error("scan passed on while seeking");
  pop_next_a: assert property (res_avail && rd ##1 res_avail |-> rdata == $past(rdata_next))
    else $error("pop lost following byte");
  result_hold_a: assert property (res_avail && !rd ##1 res_avail |-> $stable(rdata))
    else $error("result byte moved");
  seek_int_a: assert property ($fell(seek_active) |-> ##[0:2] int_req)
    else $error("no interrupt after seek");
  seek_free_a: assert property ($rose(seek_active) |-> ##[0:2] !busy)
    else $error("engine busy during seek");
  no_auto_a: assert property ($fell(seek_active) && !wr && !busy |-> !res_avail [*2])
    else $error("status returned unasked");
endmodule // disk_link_props
`default_nettype wire

// *** sim/disk_scan_seek_recal_cmds_tb_top.sv ***
// Bench: host controller and command engine joined over the byte link.
// Assumes the package, link interface and both design ends compile first.
`timescale 1ns/100ps
`default_nettype none
module disk_scan_seek_recal_cmds_tb_top;
  import fdc_pkg::*;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, dv = 1'h0, dd = 1'h0, sa;
  logic [1:0] addr = 2'h0;
  logic [7:0] wd = 8'h00, rdata, db = 8'h00, dc = 8'h00, q;
  logic [8:0] df = 9'h000;
  logic [3:0] step, sdir, home = 4'h1, rdy = 4'h7;
  int n_mismatch = 0, total_checks = 0, nst = 0, n0;
  // ----
  // Harness
  // ----
  always #5 clk = ~clk;
  always @(posedge clk) nst <= nst + $countones(step);
  fdc_link_if link();
  fdc_host_ctrl i_fdc_host_ctrl(.clk(clk), .rst(rst), .link(link), .addr(addr), .wdata(wd),
    .wr(wr), .rd(rd), .rdata(rdata));
  // Short step unit keeps a 255-step recalibrate near a thousand cycles
  fdc_cmd_engine #(.STEP_UNIT(4)) i_fdc_cmd_engine(.clk(clk), .rst(rst), .link(link),
    .step(step), .step_dir(sdir), .home_track_input(home), .drive_ready(rdy),
    .scan_active(sa), .disk_valid(dv), .disk_byte(db), .disk_done(dd), .disk_fault(df),
    .disk_cyl(dc));
  disk_link_props i_disk_link_props(.clk(clk), .rst(rst), .wr(link.wr), .wdata(link.wdata),
    .rd(link.rd), .rdata(link.rdata), .rdata_next(link.rdata_next), .res_avail(link.res_avail),
    .busy(link.busy), .int_req(link.int_req), .seek_active(link.seek_active));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Gap after each byte lets the one-cycle busy lag settle
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic get(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic wt(input int b);
    q = 8'h00;
    for (int i = 0; i < 4000 && q[b] !== 1'h1; i++)
      get(ADDR_STATUS, q);
    if (q[b] !== 1'h1)
      n_mismatch++;
  endtask
  task automatic go(input logic [7:0] op, input logic [7:0] drv, input logic [7:0] cyl);
    put(ADDR_DATA, op);
    put(ADDR_DATA, drv);
    if (op != OP_RECAL)
      put(ADDR_DATA, cyl);
  endtask
  task automatic sense(input logic [7:0] e0, input logic [7:0] e1, input bit two);
    put(ADDR_DATA, OP_SENSE);
    get(ADDR_DATA, q);
    chk(q, e0);
    if (two)
    begin
      get(ADDR_DATA, q);
      chk(q, e1);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_seek;
    sense(ST0_INVALID, 8'h00, 0);
    put(ADDR_DATA, OP_SPECIFY);
    put(ADDR_DATA, 8'hF0);
    put(ADDR_DATA, 8'h00);
    n0 = nst;
    go(OP_SEEK, 8'h01, 8'h28);
    put(ADDR_DATA, 8'h19);
    get(ADDR_STATUS, q);
    chk(q & 8'h02, 8'h00);
    get(ADDR_STATUS, q);
    chk(q & 8'h18, 8'h18);
    go(OP_SEEK, 8'h00, 8'h02);
    wt(HS_INT);
    sense(8'h20, 8'h02, 1);
    wt(HS_INT);
    sense(8'h21, 8'h28, 1);
    chk(8'(nst - n0), 8'h2A);
    chk({7'h00, sdir[1]}, 8'h01);
    put(ADDR_STATUS, 8'h08);
    get(ADDR_STATUS, q);
    chk(q & 8'h08, 8'h00);
    n0 = nst;
    go(OP_SEEK, 8'h01, 8'h05);
    wt(HS_INT);
    sense(8'h21, 8'h05, 1);
    chk(8'(nst - n0), 8'h23);
    chk({7'h00, sdir[1]}, 8'h00);
    n0 = nst;
    go(OP_SEEK, 8'h01, 8'h05);
    wt(HS_INT);
    sense(8'h21, 8'h05, 1);
    chk(8'(nst - n0), 8'h00);
    go(OP_SEEK, 8'h03, 8'h07);
    wt(HS_INT);
    sense(8'h6B, 8'h00, 1);
    $display("seek test done");
  endtask
  task automatic t_recal;
    n0 = nst;
    go(OP_RECAL, 8'h00, 8'h00);
    wt(HS_INT);
    sense(8'h20, 8'h00, 1);
    chk(8'(nst - n0), 8'h00);
    go(OP_RECAL, 8'h02, 8'h00);
    wt(HS_INT);
    sense(8'h72, 8'h00, 1);
    chk(8'(nst - n0), 8'hFF);
    $display("recalibrate test done");
  endtask
  task automatic scan(input logic [7:0] op, input logic [7:0] d, input logic [8:0] f,
    input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    go(op, 8'h00, 8'h01);
    for (int i = 2; i < 8; i++)
      put(ADDR_DATA, 8'(i));
    chk({7'h00, sa}, 8'h01);
    put(ADDR_DATA, 8'h50);
    @(posedge clk);
    db <= d;
    dv <= 1'h1;
    @(posedge clk);
    dv <= 1'h0;
    df <= f;
    dc <= f[F_CYL] ? BAD_CYL : 8'h01;
    dd <= 1'h1;
    @(posedge clk);
    dd <= 1'h0;
    wt(HS_RES);
    get(ADDR_DATA, q);
    chk(q, e0);
    get(ADDR_DATA, q);
    chk(q, e1);
    get(ADDR_DATA, q);
    chk(q, e2);
    for (int i = 1; i < 5; i++)
    begin
      get(ADDR_DATA, q);
      chk(q, 8'(i));
    end
  endtask
  task automatic t_scan;
    scan(8'hF9, 8'h4F, 9'h000, 8'h00, 8'h00, 8'h00);
    scan(8'h19, 8'h50, 9'h000, 8'h00, 8'h00, 8'h08);
    scan(8'h19, 8'h51, 9'h000, 8'h00, 8'h00, 8'h04);
    scan(8'h1D, 8'h51, 9'h000, 8'h00, 8'h00, 8'h00);
    scan(8'h1D, 8'h4F, 9'h000, 8'h00, 8'h00, 8'h04);
    scan(8'h19, 8'h4F, 9'h001, 8'h40, 8'h01, 8'h00);
    scan(8'h19, 8'h4F, 9'h002, 8'h40, 8'h04, 8'h02);
    scan(8'h19, 8'h4F, 9'h080, 8'h40, 8'h20, 8'h00);
    scan(8'h19, 8'h4F, 9'h100, 8'h40, 8'h80, 8'h00);
    scan(8'h19, 8'h4F, 9'h004, 8'h40, 8'h04, 8'h00);
    scan(8'h19, 8'h4F, 9'h008, 8'h40, 8'h20, 8'h00);
    scan(8'h1D, 8'h51, 9'h010, 8'h40, 8'h01, 8'h01);
    scan(8'h1D, 8'h51, 9'h040, 8'h40, 8'h20, 8'h20);
    scan(8'h1D, 8'h51, 9'h020, 8'h00, 8'h00, 8'h40);
    $display("scan test done");
  endtask
  // Drive 3 is never ready, so the scan ends at its last command byte
  task automatic t_scan_nr;
    go(8'h19, 8'h03, 8'h01);
    for (int i = 2; i < 8; i++)
      put(ADDR_DATA, 8'(i));
    wt(HS_RES);
    get(ADDR_DATA, q);
    chk(q, 8'h4B);
    for (int i = 0; i < 6; i++)
    begin
      get(ADDR_DATA, q);
      chk(q, (i < 2) ? 8'h00 : 8'(i - 1));
    end
    $display("not-ready scan test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_seek();
    t_recal();
    t_scan();
    t_scan_nr();
    results();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule // disk_scan_seek_recal_cmds_tb_top
`default_nettype wire
